//--- design/lsw_device.sv
// Display end: receives bytes from the serial link and writes frame memory
// Functional notes
// - Traffic accepted only while select is low
// - D/C low means command, high data
// - One bit taken per rising link clock
// - Each transfer unit is eight bits
// - Most significant bit sent first
// - Host idles link clock low
// - Host presents data before first edge
// - Link is write-only, no read path
// - Pixel is two data bytes, RGB565
// - Host sets address window before pixels
// - Address steps rows/columns per scan mode
// - Visible array is 128 by 160
// - Frame memory 48114 bytes, 132 by 162; this port stores 42768 bytes, 16-bit RGB565 only
// - Backlight lit while control is high
`timescale 1ns/1ps
module lsw_device
    import lsw_pkg::*;
#(
    parameter int MEM_COLS = LSW_MEM_COLS,
    parameter int MEM_ROWS = LSW_MEM_ROWS
) (
    input wire logic clk,
    input wire logic reset_n,
    lsw_link_if.device link,
    output logic byte_valid,
    output logic [7:0] byte_out,
    output logic byte_is_data,
    output logic pix_valid,
    output logic [15:0] pix_out,
    output logic [7:0] pix_col,
    output logic [7:0] pix_row,
    output logic backlight_lit,
    output logic panel_in_reset,
    input wire logic [7:0] rd_col,
    input wire logic [7:0] rd_row,
    output logic [15:0] rd_pix
);
    localparam int MEM_WORDS = MEM_COLS * MEM_ROWS;

    // 132x162 words of 16 bits is 42768 bytes of RGB565 store; the controller's
    // 48114-byte figure covers 18-bit mode, which this port never uses.
    logic [15:0] frame_memory [MEM_WORDS];

    logic [5:0] pins; // Synchronised link pins
    logic sel_n, dc, sck, sda, prst_n, bl;
    logic sck_prev_q, sck_prev_d; // Rising-edge detect
    logic [7:0] sh_q, sh_d; // Incoming byte
    logic [2:0] bit_q, bit_d; // Bits received
    logic bv_q, bv_d;
    logic [7:0] bo_q, bo_d;
    logic bd_q, bd_d;
    lsw_dev_st_e st_q, st_d; // Command decode state
    logic [7:0] cmd_q, cmd_d; // Command being parametered
    logic [7:0] cs_q, cs_d, ce_q, ce_d, rs_q, re_q, rs_d, re_d; // Window
    logic [7:0] col_q, col_d, row_q, row_d; // Write pointer
    logic [1:0] scan_q, scan_d; // Bit0 column down, bit1 row down
    logic hi_q, hi_d; // Second pixel byte expected
    logic [7:0] hib_q, hib_d; // First pixel byte
    logic pv_q, pv_d;
    logic [15:0] po_q, po_d;
    logic [7:0] pc_q, pc_d, pr_q, pr_d;
    logic sck_rise;
    logic [7:0] rx_byte;

    lsw_sync2 #(.WIDTH(6)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({link.panel_select_n, link.cmd_data_sel, link.sclk, link.sdata,
            link.module_reset_n, link.backlight_on}),
        .reset_val(6'h20), // Deselected, panel held in reset, backlight dark
        .sync_out(pins)
    );
    assign {sel_n, dc, sck, sda, prst_n, bl} = pins;

    assign sck_rise = sck && !sck_prev_q && !sel_n;
    assign rx_byte = {sh_q[6:0], sda};
    assign byte_valid = bv_q;
    assign byte_out = bo_q;
    assign byte_is_data = bd_q;
    assign pix_valid = pv_q;
    assign pix_out = po_q;
    assign pix_col = pc_q;
    assign pix_row = pr_q;
    assign backlight_lit = bl;
    assign panel_in_reset = !prst_n;
    // Local read port only; nothing returns on the link
    assign rd_pix = frame_memory[int'(rd_row) * MEM_COLS + int'(rd_col)];

    // Next position in the window, direction from scan mode
    function automatic logic [15:0] step_addr(input logic [7:0] c, input logic [7:0] r,
            input logic [7:0] cs, input logic [7:0] ce, input logic [7:0] rs,
            input logic [7:0] re, input logic [1:0] scan);
        logic [7:0] nc;
        logic [7:0] nr;
        nc = c;
        nr = r;
        if (c == (scan[0] ? cs : ce)) begin
            nc = scan[0] ? ce : cs;
            if (r == (scan[1] ? rs : re)) nr = scan[1] ? re : rs;
            else nr = scan[1] ? r - 8'h01 : r + 8'h01;
        end else begin
            nc = scan[0] ? c - 8'h01 : c + 8'h01;
        end
        return {nc, nr};
    endfunction

    // Bit assembly: a deselect drops any partial byte
    always_comb begin
        sck_prev_d = sck;
        sh_d = sh_q;
        bit_d = bit_q;
        bv_d = 1'b0;
        bo_d = bo_q;
        bd_d = bd_q;
        if (sel_n || !prst_n) begin
            bit_d = LSW_BIT_CNT_RST;
        end else if (sck_rise) begin
            sh_d = rx_byte;
            bit_d = bit_q + 3'h1;
            if (bit_q == LSW_BIT_LAST) begin
                bv_d = 1'b1;
                bo_d = rx_byte;
                bd_d = dc;
            end
        end
    end

    // Command decode, window set-up and pixel writes
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        cs_d = cs_q;
        ce_d = ce_q;
        rs_d = rs_q;
        re_d = re_q;
        col_d = col_q;
        row_d = row_q;
        scan_d = scan_q;
        hi_d = hi_q;
        hib_d = hib_q;
        pv_d = 1'b0;
        po_d = po_q;
        pc_d = pc_q;
        pr_d = pr_q;
        if (bv_q && !bd_q) begin
            // Any command byte restarts decoding
            cmd_d = bo_q;
            hi_d = 1'b0;
            st_d = LSW_D_CMD;
            case (bo_q)
                LSW_CMD_COL_SET, LSW_CMD_ROW_SET, LSW_CMD_SCAN: st_d = LSW_D_P0;
                LSW_CMD_MEM_WR: begin
                    // Pointer starts at window corner fixed by scan mode
                    st_d = LSW_D_PIX;
                    col_d = scan_q[0] ? ce_q : cs_q;
                    row_d = scan_q[1] ? re_q : rs_q;
                end
                default: st_d = LSW_D_CMD;
            endcase
        end else if (bv_q && bd_q) begin
            case (st_q)
                LSW_D_P0: begin
                    if (cmd_q == LSW_CMD_SCAN) begin
                        scan_d = bo_q[7:6];
                        st_d = LSW_D_CMD;
                    end else begin
                        st_d = LSW_D_P1; // High byte of start ignored
                    end
                end
                LSW_D_P1: begin
                    if (cmd_q == LSW_CMD_COL_SET) cs_d = bo_q;
                    else rs_d = bo_q;
                    st_d = LSW_D_P2;
                end
                LSW_D_P2: st_d = LSW_D_P3;
                LSW_D_P3: begin
                    if (cmd_q == LSW_CMD_COL_SET) ce_d = bo_q;
                    else re_d = bo_q;
                    st_d = LSW_D_CMD;
                end
                LSW_D_PIX: begin
                    if (!hi_q) begin
                        hib_d = bo_q;
                        hi_d = 1'b1;
                    end else begin
                        hi_d = 1'b0;
                        pv_d = 1'b1;
                        po_d = {hib_q, bo_q};
                        pc_d = col_q;
                        pr_d = row_q;
                        {col_d, row_d} = step_addr(col_q, row_q, cs_q, ce_q, rs_q, re_q,
                            scan_q);
                    end
                end
                default: st_d = LSW_D_CMD;
            endcase
        end
    end

    // Frame memory write, dropped outside the stored area
    always_ff @(posedge clk) begin
        if (pv_q && int'(pc_q) < MEM_COLS && int'(pr_q) < MEM_ROWS) begin
            frame_memory[int'(pr_q) * MEM_COLS + int'(pc_q)] <= po_q;
        end
    end

    // State registers; panel reset pin clears decode like a power-on reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_q <= 1'b0;
            sh_q <= LSW_BYTE_RST;
            bit_q <= LSW_BIT_CNT_RST;
            bv_q <= 1'b0;
            bo_q <= LSW_BYTE_RST;
            bd_q <= 1'b0;
            st_q <= LSW_D_CMD;
            cmd_q <= LSW_BYTE_RST;
            cs_q <= LSW_COL_RST;
            ce_q <= LSW_COL_END_RST;
            rs_q <= LSW_COL_RST;
            re_q <= LSW_ROW_END_RST;
            col_q <= LSW_COL_RST;
            row_q <= LSW_COL_RST;
            scan_q <= LSW_SCAN_RST;
            hi_q <= 1'b0;
            hib_q <= LSW_BYTE_RST;
            pv_q <= 1'b0;
            po_q <= LSW_PIX_RST;
            pc_q <= LSW_COL_RST;
            pr_q <= LSW_COL_RST;
        end else if (!prst_n) begin
            st_q <= LSW_D_CMD;
            bit_q <= LSW_BIT_CNT_RST;
            bv_q <= 1'b0;
            pv_q <= 1'b0;
            hi_q <= 1'b0;
            cs_q <= LSW_COL_RST;
            ce_q <= LSW_COL_END_RST;
            rs_q <= LSW_COL_RST;
            re_q <= LSW_ROW_END_RST;
            scan_q <= LSW_SCAN_RST;
            sck_prev_q <= sck_prev_d;
        end else begin
            sck_prev_q <= sck_prev_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            bv_q <= bv_d;
            bo_q <= bo_d;
            bd_q <= bd_d;
            st_q <= st_d;
            cmd_q <= cmd_d;
            cs_q <= cs_d;
            ce_q <= ce_d;
            rs_q <= rs_d;
            re_q <= re_d;
            col_q <= col_d;
            row_q <= row_d;
            scan_q <= scan_d;
            hi_q <= hi_d;
            hib_q <= hib_d;
            pv_q <= pv_d;
            po_q <= po_d;
            pc_q <= pc_d;
            pr_q <= pr_d;
        end
    end
endmodule

//--- design/lsw_pkg.sv
// Shared constants and types for the display serial write port
package lsw_pkg;
    localparam int LSW_BYTE_BITS = 8;
    localparam logic [2:0] LSW_BIT_CNT_RST = 3'h0;
    localparam logic [2:0] LSW_BIT_LAST = 3'h7;
    localparam logic [7:0] LSW_BYTE_RST = 8'h00;
    localparam logic [15:0] LSW_PIX_RST = 16'h0000;
    localparam int LSW_COLS = 128;
    localparam int LSW_ROWS = 160;
    localparam int LSW_MEM_COLS = 132;
    localparam int LSW_MEM_ROWS = 162;
    localparam int LSW_MEM_BYTES = 48114;
    localparam logic [7:0] LSW_CMD_COL_SET = 8'h2A;
    localparam logic [7:0] LSW_CMD_ROW_SET = 8'h2B;
    localparam logic [7:0] LSW_CMD_MEM_WR = 8'h2C;
    localparam logic [7:0] LSW_CMD_SCAN = 8'h36;
    localparam logic [7:0] LSW_CMD_SWRESET = 8'h01;
    localparam logic [7:0] LSW_COL_RST = 8'h00;
    localparam logic [7:0] LSW_COL_END_RST = 8'h7F;
    localparam logic [7:0] LSW_ROW_END_RST = 8'h9F;
    localparam logic [1:0] LSW_SCAN_RST = 2'h0;
    localparam int LSW_LINK_DIV = 4;
    localparam int LSW_RESET_PULSE = 16;
    localparam int LSW_GUARD = 2;
    typedef enum logic [2:0] {
        LSW_H_IDLE = 3'b000,
        LSW_H_SEL = 3'b001,
        LSW_H_LOW = 3'b011,
        LSW_H_HIGH = 3'b010,
        LSW_H_DESEL = 3'b110
    } lsw_host_st_e;
    typedef enum logic [2:0] {
        LSW_D_CMD = 3'b000,
        LSW_D_P0 = 3'b001,
        LSW_D_P1 = 3'b011,
        LSW_D_P2 = 3'b010,
        LSW_D_P3 = 3'b110,
        LSW_D_PIX = 3'b111
    } lsw_dev_st_e;
endpackage

//--- design/lsw_link_if.sv
// Interface joining the host and display ends of the serial link
`timescale 1ns/1ps
interface lsw_link_if;
    logic panel_select_n; // Active-low select
    logic cmd_data_sel; // Low command, high data
    logic sclk; // Link clock, idles low
    logic sdata; // Write data, MSB first
    logic module_reset_n; // Panel reset
    logic backlight_on; // High lights the backlight
    modport host (
        output panel_select_n, cmd_data_sel, sclk, sdata, module_reset_n, backlight_on
    );
    modport device (
        input panel_select_n, cmd_data_sel, sclk, sdata, module_reset_n, backlight_on
    );
endinterface

//--- design/lsw_sync2.sv
// Two-flop synchroniser for pins entering the clk domain
`timescale 1ns/1ps
module lsw_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_val,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q; // First stage, read only by second
    logic [WIDTH-1:0] sync_q; // Second stage
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // Pins are flipped by their idle level before the flops and flipped back after,
    // so a flop cleared to zero reads as the idle level and live data passes unchanged
    always_comb begin
        meta_d = async_in ^ reset_val;
        sync_d = meta_q;
    end

    // Reset to zero; reset_val is merged after the flops so no port feeds reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    // Idle value flips polarity so a zero-reset flop still reads as the idle level
    assign sync_out = sync_q ^ reset_val;
endmodule

//--- design/lsw_host.sv
// Host end: shifts command and data bytes onto the serial link
`timescale 1ns/1ps
module lsw_host
    import lsw_pkg::*;
#(
    parameter int DIV = LSW_LINK_DIV
) (
    input wire logic clk,
    input wire logic reset_n,
    lsw_link_if.host link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_byte,
    input wire logic req_is_data,
    input wire logic req_last,
    input wire logic panel_reset_req,
    input wire logic backlight_req,
    output logic busy
);
    lsw_host_st_e st_q, st_d; // Link state
    logic [7:0] sh_q, sh_d; // Outgoing byte
    logic [2:0] bit_q, bit_d; // Bits already sent
    logic [7:0] div_q, div_d; // Half-period counter
    logic dc_q, dc_d; // Held for the whole byte
    logic last_q, last_d; // Deselect after this byte
    logic rst_pend_q, rst_pend_d; // Reset pulse active
    logic [7:0] rst_cnt_q, rst_cnt_d; // Reset pulse length
    logic bl_q, bl_d; // Backlight level
    logic div_end;

    assign div_end = (div_q == 8'(DIV - 1));
    // A reset request in idle wins, so ready drops rather than a byte being lost
    assign req_ready = (st_q == LSW_H_IDLE || st_q == LSW_H_DESEL) && !rst_pend_q
        && (st_q == LSW_H_IDLE || div_end) && !(panel_reset_req && st_q == LSW_H_IDLE);
    assign busy = (st_q != LSW_H_IDLE) || rst_pend_q;

    // Link pins all derive from flops; select and clock are decoded from st_q
    assign link.panel_select_n = !(st_q == LSW_H_SEL || st_q == LSW_H_LOW
        || st_q == LSW_H_HIGH);
    assign link.sclk = (st_q == LSW_H_HIGH);
    assign link.sdata = sh_q[7];
    assign link.cmd_data_sel = dc_q;
    assign link.module_reset_n = !rst_pend_q;
    assign link.backlight_on = bl_q;

    // Shift sequencing: data set while clock low, taken on rising edge
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        dc_d = dc_q;
        last_d = last_q;
        div_d = div_end ? 8'h00 : div_q + 8'h01;
        rst_pend_d = rst_pend_q;
        rst_cnt_d = rst_cnt_q;
        bl_d = backlight_req;
        if (rst_pend_q) begin
            // Reset pulse must end before any command goes out
            div_d = 8'h00;
            if (rst_cnt_q == 8'(LSW_RESET_PULSE - 1)) begin
                rst_pend_d = 1'b0;
            end else begin
                rst_cnt_d = rst_cnt_q + 8'h01;
            end
        end else if (panel_reset_req && st_q == LSW_H_IDLE) begin
            rst_pend_d = 1'b1;
            rst_cnt_d = 8'h00;
        end else begin
            case (st_q)
                LSW_H_IDLE: begin
                    div_d = 8'h00;
                end
                LSW_H_SEL: begin
                    // Select settles one half period, then a low half period passes, before first rising edge
                    if (div_end) st_d = LSW_H_LOW;
                end
                LSW_H_LOW: begin
                    if (div_end) st_d = LSW_H_HIGH;
                end
                LSW_H_HIGH: begin
                    if (div_end) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        bit_d = bit_q + 3'h1;
                        if (bit_q == LSW_BIT_LAST) begin
                            // Eight clocks per byte
                            st_d = last_q ? LSW_H_DESEL : LSW_H_SEL;
                        end else begin
                            st_d = LSW_H_LOW;
                        end
                    end
                end
                LSW_H_DESEL: begin
                    if (div_end) st_d = LSW_H_IDLE;
                end
                default: st_d = LSW_H_IDLE;
            endcase
            // New byte loads only between bytes, so D/C never moves mid-byte
            if (req_valid && req_ready) begin
                sh_d = req_byte;
                dc_d = req_is_data;
                last_d = req_last;
                bit_d = LSW_BIT_CNT_RST;
                st_d = LSW_H_SEL;
                div_d = 8'h00;
            end
            // Back-to-back bytes: deselect after every byte, even when last is not set
            if (st_q == LSW_H_HIGH && div_end && bit_q == LSW_BIT_LAST && !last_q) begin
                st_d = LSW_H_DESEL;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= LSW_H_IDLE;
            sh_q <= LSW_BYTE_RST;
            bit_q <= LSW_BIT_CNT_RST;
            div_q <= 8'h00;
            dc_q <= 1'b0;
            last_q <= 1'b0;
            rst_pend_q <= 1'b1;
            rst_cnt_q <= 8'h00;
            bl_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            div_q <= div_d;
            dc_q <= dc_d;
            last_q <= last_d;
            rst_pend_q <= rst_pend_d;
            rst_cnt_q <= rst_cnt_d;
            bl_q <= bl_d;
        end
    end
endmodule

//--- tb/lsw_checker.sv
// Concurrent checks on the serial link between host and display ends
`timescale 1ns/1ps
module lsw_checker
    import lsw_pkg::*;
#(
    parameter int DIV = LSW_LINK_DIV,
    parameter int PULSE = LSW_RESET_PULSE
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic panel_select_n,
    input wire logic cmd_data_sel,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic module_reset_n,
    input wire logic backlight_on
);
    logic [7:0] hi_q, hi_d; // Cycles the link clock has been high
    logic [7:0] rise_q, rise_d; // Link clock rises in this selection
    logic [7:0] rlow_q, rlow_d; // Cycles the panel reset has been low
    logic sclk_q; // Link clock one cycle ago
    // Next counts; the reset counter saturates so a stuck pin cannot wrap into a pass
    always_comb begin
        hi_d = sclk ? hi_q + 8'h01 : 8'h00;
        rise_d = panel_select_n ? 8'h00 : rise_q + {7'h00, sclk & ~sclk_q};
        rlow_d = module_reset_n ? 8'h00 : rlow_q + {7'h00, rlow_q != 8'hFF};
    end
    // Register the helper counts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_q <= 8'h00;
            rise_q <= 8'h00;
            rlow_q <= 8'h00;
            sclk_q <= 1'b0;
        end else begin
            hi_q <= hi_d;
            rise_q <= rise_d;
            rlow_q <= rlow_d;
            sclk_q <= sclk;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_clock_idle_low: assert property (panel_select_n && $past(panel_select_n) |-> !sclk)
        else $error("link clock high while deselected");
    a_rise_needs_select: assert property ($rose(sclk) |-> !panel_select_n)
        else $error("link clock rise without select");
    a_data_set_up: assert property ($rose(sclk) |-> $stable(sdata) && $stable(cmd_data_sel))
        else $error("data changed on the sampling edge");
    a_data_held_high: assert property (sclk && $past(sclk) |-> $stable(sdata))
        else $error("data changed while link clock high");
    a_dc_held_byte: assert property (!panel_select_n && !$past(panel_select_n)
        |-> $stable(cmd_data_sel))
        else $error("command/data select changed inside a byte");
    a_high_phase_len: assert property ($fell(sclk) |-> hi_q == DIV)
        else $error("link clock high phase has wrong length");
    a_eight_rises: assert property ($rose(panel_select_n) |-> rise_q == 8'h08)
        else $error("byte did not carry eight clocks");
    // One clock of slack covers where the host starts its own count
    a_reset_pulse_len: assert property ($rose(module_reset_n) |-> rlow_q >= PULSE - 1)
        else $error("panel reset pulse too short");
    a_no_select_in_reset: assert property (!module_reset_n |-> panel_select_n)
        else $error("panel selected while held in reset");
    c_cmd_byte: cover property ($rose(sclk) && !cmd_data_sel);
    c_data_byte: cover property ($rose(sclk) && cmd_data_sel);
    c_reset_pulse: cover property ($rose(module_reset_n));
    c_backlight: cover property ($rose(backlight_on));
endmodule

//--- tb/tb_lcd_serial_write_port.sv
// Self-checking bench joining the host and display ends over the link
`timescale 1ns/1ps
module tb_lcd_serial_write_port
    import lsw_pkg::*;
;
    // One byte sent, with the pixel it should complete
    typedef struct packed {
        logic [7:0] b;
        logic dc;
        logic last;
        logic pv;
        logic [7:0] col;
        logic [7:0] row;
    } lsw_row_s;
    logic clk = 1'b0; // 50 MHz system clock
    logic reset_n = 1'b0; // Async reset, active low
    logic req_valid = 1'b0, req_is_data = 1'b0, req_last = 1'b0; // Host request
    logic panel_reset_req = 1'b0, backlight_req = 1'b0; // Host pin requests
    logic [7:0] req_byte = 8'h00, rd_col = 8'h00, rd_row = 8'h00;
    logic req_ready, busy, byte_valid, byte_is_data, pix_valid, backlight_lit, panel_in_reset;
    logic [7:0] byte_out, pix_col, pix_row, prev_b;
    logic [15:0] pix_out, rd_pix;
    int errors = 0;
    int n_tests = 0;
    // Default window first, then an explicit window and three pixels that wrap a row,
    // then both scan directions reversed and three pixels stepping down
    lsw_row_s rows [29] = '{
        '{8'h2C, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'h12, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00},
        '{8'h34, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00}, '{8'h2A, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00},
        '{8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'h05, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00},
        '{8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'h06, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00},
        '{8'h2B, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00},
        '{8'h0A, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00},
        '{8'h0B, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'h2C, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00},
        '{8'hA5, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{8'h5A, 1'b1, 1'b1, 1'b1, 8'h05, 8'h0A},
        '{8'h81, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{8'h7E, 1'b1, 1'b1, 1'b1, 8'h06, 8'h0A},
        '{8'hFF, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{8'h00, 1'b1, 1'b1, 1'b1, 8'h05, 8'h0B},
        '{8'h36, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'hC0, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00},
        '{8'h2C, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00}, '{8'h3C, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00},
        '{8'hC3, 1'b1, 1'b1, 1'b1, 8'h06, 8'h0B}, '{8'h0F, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00},
        '{8'hF0, 1'b1, 1'b1, 1'b1, 8'h05, 8'h0B}, '{8'h96, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00},
        '{8'h69, 1'b1, 1'b1, 1'b1, 8'h06, 8'h0A}
    };
    lsw_link_if link ();
    lsw_host lsw_host_inst (.clk(clk), .reset_n(reset_n), .link(link), .req_valid(req_valid),
        .req_ready(req_ready), .req_byte(req_byte), .req_is_data(req_is_data),
        .req_last(req_last), .panel_reset_req(panel_reset_req),
        .backlight_req(backlight_req), .busy(busy));
    lsw_device lsw_device_inst (.clk(clk), .reset_n(reset_n), .link(link),
        .byte_valid(byte_valid), .byte_out(byte_out), .byte_is_data(byte_is_data),
        .pix_valid(pix_valid), .pix_out(pix_out), .pix_col(pix_col), .pix_row(pix_row),
        .backlight_lit(backlight_lit), .panel_in_reset(panel_in_reset), .rd_col(rd_col),
        .rd_row(rd_row), .rd_pix(rd_pix));
    lsw_checker lsw_checker_inst (.clk(clk), .reset_n(reset_n),
        .panel_select_n(link.panel_select_n), .cmd_data_sel(link.cmd_data_sel),
        .sclk(link.sclk), .sdata(link.sdata), .module_reset_n(link.module_reset_n),
        .backlight_on(link.backlight_on));
    // Half period of 10 ns gives 50 MHz
    always #10 clk = ~clk;
    // Verdict and end of run
    task tally_and_finish;
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Compare tasks, one per result width
    task chk1(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Inputs move 1 ns after the edge so no race with the design's flops
    task tick;
        @(posedge clk);
        #1;
    endtask
    // Selects the flag that a wait watches
    function automatic logic pick(input int s);
        return s == 0 ? backlight_lit : s == 1 ? panel_in_reset : s == 2 ? req_ready : byte_valid;
    endfunction
    // Bounded wait; running out counts a mismatch and ends the run
    task wait_for(input int s, input logic v, input string nm);
        int i;
        for (i = 0; i < 300 && pick(s) !== v; i++) begin
            tick;
        end
        if (pick(s) !== v) begin
            errors++;
            $display("FAIL %s expected %b seen timeout", nm, v);
            tally_and_finish;
        end
    endtask
    // Send one byte through the host and check what the display end makes of it
    task send(input lsw_row_s r);
        wait_for(2, 1'b1, "req_ready");
        req_valid = 1'b1;
        req_byte = r.b;
        req_is_data = r.dc;
        req_last = r.last;
        tick;
        req_valid = 1'b0;
        wait_for(3, 1'b1, "byte_valid");
        chk8("byte_out", r.b, byte_out);
        chk1("byte_is_data", r.dc, byte_is_data);
        tick;
        chk1("pix_valid", r.pv, pix_valid);
        if (r.pv) begin
            chk16("pix_out", {prev_b, r.b}, pix_out);
            chk8("pix_col", r.col, pix_col);
            chk8("pix_row", r.row, pix_row);
        end
        prev_b = r.b;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1;
        chk1("busy", 1'b1, busy);
        chk1("req_ready", 1'b0, req_ready);
        chk1("byte_valid", 1'b0, byte_valid);
        chk1("panel_in_reset", 1'b1, panel_in_reset);
        reset_n = 1'b1;
        foreach (rows[i]) begin
            send(rows[i]);
        end
        // Frame memory holds what was drawn
        // A clock edge passes first so the last pixel's write has landed
        rd_col = 8'h05;
        rd_row = 8'h0A;
        tick;
        chk16("rd_pix", 16'hA55A, rd_pix);
        rd_row = 8'h0B;
        tick;
        chk16("rd_pix", 16'h0FF0, rd_pix);
        rd_col = 8'h00;
        rd_row = 8'h00;
        tick;
        chk16("rd_pix", 16'h1234, rd_pix);
        // Backlight follows its control both ways
        backlight_req = 1'b1;
        wait_for(0, 1'b1, "backlight_lit");
        backlight_req = 1'b0;
        wait_for(0, 1'b0, "backlight_lit");
        // Panel reset mid-stream must drop the pixel decode
        wait_for(2, 1'b1, "req_ready");
        panel_reset_req = 1'b1;
        tick;
        panel_reset_req = 1'b0;
        wait_for(1, 1'b1, "panel_in_reset");
        chk1("busy", 1'b1, busy);
        wait_for(1, 1'b0, "panel_in_reset");
        send('{8'h77, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00});
        send('{8'h88, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00});
        tally_and_finish;
    end
endmodule
